// ---- gain_applier.sv ----
// Applies a requested mixer gain code immediately, at a zero crossing, or by ramping.
// Assumes step_i is a one-cycle pulse and zero_cross_i is synchronous to mclk_i.
`timescale 1ns/10ps
module gain_applier (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic [mic_mix_pkg::GAIN_W-1:0] target_i,
	input wire logic ramp_i,
	input wire logic zc_i,
	input wire logic step_i,
	input wire logic zero_cross_i,
	output logic [mic_mix_pkg::GAIN_W-1:0] gain_o
);

	mic_mix_pkg::gain_ctl_t q;
	mic_mix_pkg::gain_ctl_t d;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic up;
		up = q.applied < target_i;
		d = q;
		case (q.st)
			mic_mix_pkg::G_IDLE: begin
				if (q.applied != target_i) begin
					if (ramp_i) begin
						d.st = mic_mix_pkg::G_RAMP;
					end else if (zc_i) begin
						d.st = mic_mix_pkg::G_WAIT_ZC;
					end else begin
						d.applied = target_i;
					end
				end
			end
			mic_mix_pkg::G_WAIT_ZC: begin
				if (ramp_i) begin
					d.st = mic_mix_pkg::G_RAMP;
				end else if (!zc_i || zero_cross_i || q.applied == target_i) begin
					d.applied = target_i;
					d.st = mic_mix_pkg::G_IDLE;
				end
			end
			mic_mix_pkg::G_RAMP: begin
				if (!ramp_i || q.applied == target_i) begin
					d.st = mic_mix_pkg::G_IDLE;
				end else if (step_i) begin
					d.applied = up ? q.applied + 4'h1 : q.applied - 4'h1;
				end
			end
			default: begin
				d.st = mic_mix_pkg::G_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			q <= '{st: mic_mix_pkg::G_IDLE, applied: mic_mix_pkg::GAIN_RST};
		end else begin
			q <= d;
		end
	end

	assign gain_o = q.applied;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	a_instant_gain_apply: assert property (
		(q.st == mic_mix_pkg::G_IDLE && !ramp_i && !zc_i) |=> gain_o == $past(target_i))
		else $error("gain not applied at once");
	a_zc_gain_holds: assert property (
		(q.st == mic_mix_pkg::G_WAIT_ZC && zc_i && !ramp_i && !zero_cross_i
		&& q.applied != target_i) |=> $stable(gain_o))
		else $error("gain moved before zero crossing");
	a_zc_gain_applies: assert property (
		(q.st == mic_mix_pkg::G_WAIT_ZC && !ramp_i && zero_cross_i) |=> gain_o == $past(target_i))
		else $error("gain not applied at zero crossing");
	a_ramp_step_up: assert property (
		(q.st == mic_mix_pkg::G_RAMP && ramp_i && step_i && gain_o < target_i)
		|=> gain_o == $past(gain_o) + 4'h1)
		else $error("ramp step up wrong");
	a_ramp_step_down: assert property (
		(q.st == mic_mix_pkg::G_RAMP && ramp_i && step_i && gain_o > target_i)
		|=> gain_o == $past(gain_o) - 4'h1)
		else $error("ramp step down wrong");
	a_ramp_over_zc: assert property (
		ramp_i |=> q.st != mic_mix_pkg::G_WAIT_ZC)
		else $error("zero cross wait while ramping");
	a_ramp_ignores_zc: assert property (
		(q.st == mic_mix_pkg::G_RAMP && ramp_i && !step_i) |=> $stable(gain_o))
		else $error("gain moved between ramp steps");

endmodule

// ---- mic_mix_pkg.sv ----
// Constants, field layouts and carrier types for the record front-end register bank.
// Assumes one 100 MHz register clock and a synchronous active-high reset.
package mic_mix_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int RAMP_STEP_NS = 1000;
	localparam int RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RAMP_CNT_W = 7;
	localparam logic [RAMP_CNT_W-1:0] RAMP_LAST = RAMP_CNT_W'(RAMP_STEP_CYC - 1);

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_MIX1_CTRL = 8'h2c;
	localparam logic [7:0] ADDR_MIX1_GAIN = 8'h2d;
	localparam logic [7:0] ADDR_MIX2_CTRL = 8'h2e;
	localparam logic [7:0] ADDR_MIX2_GAIN = 8'h2f;
	localparam logic [7:0] ADDR_SRC = 8'hbb;
	localparam logic [7:0] ADDR_BIAS_SETUP = 8'hfc;
	localparam logic [7:0] ADDR_BIAS_EN = 8'hfd;

	// ------------------------------------------------------------------
	// Field positions and widths
	// ------------------------------------------------------------------
	localparam int MIX_AMP_EN_BIT = 7;
	localparam int MIX_MUTE_BIT = 6;
	localparam int MIX_RAMP_BIT = 5;
	localparam int MIX_ZC_BIT = 4;
	localparam int MIX_EN_BIT = 3;
	localparam int GAIN_W = 4;
	localparam int SRC_W = 2;
	localparam int LVL_W = 3;
	localparam int BIAS2_LP_BIT = 7;
	localparam int BIAS2_LVL_LSB = 4;
	localparam int BIAS1_LP_BIT = 3;
	localparam int BIAS1_LVL_LSB = 0;
	localparam int BIAS2_EN_BIT = 4;
	localparam int BIAS1_EN_BIT = 0;
	localparam logic [7:0] BIAS_EN_MASK = 8'h11;
	localparam logic [7:0] GAIN_MASK = 8'h0f;
	localparam logic [7:0] SRC_MASK = 8'h03;
	localparam logic [7:0] MIX_CTRL_MASK = 8'hf8;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic amp_en;
		logic mute;
		logic ramp;
		logic zero_cross_update;
		logic mix_en;
	} mixer_ctrl_t;

	typedef struct packed {
		logic low_power;
		logic [LVL_W-1:0] level;
		logic enable;
	} bias_t;

	typedef enum logic [1:0] {
		G_IDLE = 2'h0,
		G_WAIT_ZC = 2'h1,
		G_RAMP = 2'h3
	} gain_state_t;

	typedef struct packed {
		gain_state_t st;
		logic [GAIN_W-1:0] applied;
	} gain_ctl_t;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [SRC_W-1:0] SRC_RST = 2'h0;
	localparam logic [GAIN_W-1:0] GAIN_RST = 4'h3;
	localparam bias_t BIAS_RST = '{low_power: 1'h0, level: 3'h0, enable: 1'h0};
	localparam mixer_ctrl_t MIX_CTRL_RST = '{amp_en: 1'h0, mute: 1'h1, ramp: 1'h0,
		zero_cross_update: 1'h0, mix_en: 1'h1};

	// ------------------------------------------------------------------
	// Control byte packing
	// ------------------------------------------------------------------
	function automatic logic [7:0] pack_mix(mixer_ctrl_t m);
		logic [7:0] v;
		v = 8'h00;
		v[MIX_AMP_EN_BIT] = m.amp_en;
		v[MIX_MUTE_BIT] = m.mute;
		v[MIX_RAMP_BIT] = m.ramp;
		v[MIX_ZC_BIT] = m.zero_cross_update;
		v[MIX_EN_BIT] = m.mix_en;
		return v;
	endfunction

	function automatic mixer_ctrl_t unpack_mix(logic [7:0] v);
		mixer_ctrl_t m;
		m.amp_en = v[MIX_AMP_EN_BIT];
		m.mute = v[MIX_MUTE_BIT];
		m.ramp = v[MIX_RAMP_BIT];
		m.zero_cross_update = v[MIX_ZC_BIT];
		m.mix_en = v[MIX_EN_BIT];
		return m;
	endfunction

endpackage

// ---- mic_mix_regs.sv ----
// Register bank for the second preamp source, the two bias regulators and two input mixers.
// Assumes a synchronous register port on mclk_i; fields other than the two mixer gains drive analog controls directly.
//
// Contract
// - Second preamp source is two bits, resets 0; 00 diff, 01 P, 10 N.
// - Bias level fields at 6:4 and 2:0 reset 0; 1.6 V to 3.0 V.
// - Bias low-power bits at 7 and 3 reset 0; one enables low power.
// - Enable register bit 4 drives regulator two, bit 0 regulator one; reset off.
// - Mixer control bit 7 enables the amplifier; resets to zero.
// - Mixer control bit 6 mutes the amplifier; resets to one.
// - Zero-cross bit 4 defers gain changes to a signal zero crossing.
// - Ramp bit 5 steps gain changes gradually; clear, with zero-cross bit 4 also clear, applies them at once.
// - With ramp and zero-cross both set, ramping wins and zero-cross is ignored.
// - Mixer control bit 3 is the mixer enable; resets to one.
// - Mixer gain is four bits, resets 0x3; -4.5 dB plus 1.5 dB steps.
`timescale 1ns/10ps
module mic_mix_regs (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire mic_mix_pkg::reg_req_t reg_req_i,
	input wire logic mixer_one_signal_zero_i,
	input wire logic mixer_two_signal_zero_i,
	output logic [7:0] reg_rdata_o,
	output logic [mic_mix_pkg::SRC_W-1:0] preamp_two_src_o,
	output mic_mix_pkg::bias_t bias_one_o,
	output mic_mix_pkg::bias_t bias_two_o,
	output mic_mix_pkg::mixer_ctrl_t mixer_one_o,
	output mic_mix_pkg::mixer_ctrl_t mixer_two_o,
	output logic [mic_mix_pkg::GAIN_W-1:0] mixer_one_gain_o,
	output logic [mic_mix_pkg::GAIN_W-1:0] mixer_two_gain_o
);

	typedef struct packed {
		logic [mic_mix_pkg::SRC_W-1:0] src;
		mic_mix_pkg::bias_t b1;
		mic_mix_pkg::bias_t b2;
		mic_mix_pkg::mixer_ctrl_t m1;
		mic_mix_pkg::mixer_ctrl_t m2;
		logic [mic_mix_pkg::GAIN_W-1:0] g1;
		logic [mic_mix_pkg::GAIN_W-1:0] g2;
		logic [mic_mix_pkg::RAMP_CNT_W-1:0] div;
		logic step;
		logic [7:0] rdata;
	} regs_t;

	localparam regs_t REGS_RST = '{
		src: mic_mix_pkg::SRC_RST,
		b1: mic_mix_pkg::BIAS_RST,
		b2: mic_mix_pkg::BIAS_RST,
		m1: mic_mix_pkg::MIX_CTRL_RST,
		m2: mic_mix_pkg::MIX_CTRL_RST,
		g1: mic_mix_pkg::GAIN_RST,
		g2: mic_mix_pkg::GAIN_RST,
		div: '0,
		step: 1'h0,
		rdata: 8'h00
	};

	regs_t q;
	regs_t d;

	// ------------------------------------------------------------------
	// Read decode
	// ------------------------------------------------------------------
	function automatic logic [7:0] read_reg(regs_t r, logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			mic_mix_pkg::ADDR_MIX1_CTRL: v = mic_mix_pkg::pack_mix(r.m1);
			mic_mix_pkg::ADDR_MIX2_CTRL: v = mic_mix_pkg::pack_mix(r.m2);
			mic_mix_pkg::ADDR_MIX1_GAIN: v = {4'h0, r.g1};
			mic_mix_pkg::ADDR_MIX2_GAIN: v = {4'h0, r.g2};
			mic_mix_pkg::ADDR_SRC: v = {6'h00, r.src};
			mic_mix_pkg::ADDR_BIAS_SETUP: begin
				v[mic_mix_pkg::BIAS2_LP_BIT] = r.b2.low_power;
				v[mic_mix_pkg::BIAS2_LVL_LSB +: mic_mix_pkg::LVL_W] = r.b2.level;
				v[mic_mix_pkg::BIAS1_LP_BIT] = r.b1.low_power;
				v[mic_mix_pkg::BIAS1_LVL_LSB +: mic_mix_pkg::LVL_W] = r.b1.level;
			end
			mic_mix_pkg::ADDR_BIAS_EN: begin
				v[mic_mix_pkg::BIAS2_EN_BIT] = r.b2.enable;
				v[mic_mix_pkg::BIAS1_EN_BIT] = r.b1.enable;
			end
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		d = q;
		d.step = 1'h0;
		if (q.div == mic_mix_pkg::RAMP_LAST) begin
			d.div = '0;
			d.step = 1'h1;
		end else begin
			d.div = q.div + 1'b1;
		end
		if (reg_req_i.wr) begin
			case (reg_req_i.addr)
				mic_mix_pkg::ADDR_SRC: begin
					d.src = reg_req_i.wdata[mic_mix_pkg::SRC_W-1:0];
				end
				mic_mix_pkg::ADDR_BIAS_SETUP: begin
					d.b2.level = reg_req_i.wdata[mic_mix_pkg::BIAS2_LVL_LSB +: mic_mix_pkg::LVL_W];
					d.b1.level = reg_req_i.wdata[mic_mix_pkg::BIAS1_LVL_LSB +: mic_mix_pkg::LVL_W];
					d.b2.low_power = reg_req_i.wdata[mic_mix_pkg::BIAS2_LP_BIT];
					d.b1.low_power = reg_req_i.wdata[mic_mix_pkg::BIAS1_LP_BIT];
				end
				mic_mix_pkg::ADDR_BIAS_EN: begin
					d.b2.enable = reg_req_i.wdata[mic_mix_pkg::BIAS2_EN_BIT];
					d.b1.enable = reg_req_i.wdata[mic_mix_pkg::BIAS1_EN_BIT];
				end
				mic_mix_pkg::ADDR_MIX1_CTRL: begin
					d.m1 = mic_mix_pkg::unpack_mix(reg_req_i.wdata);
				end
				mic_mix_pkg::ADDR_MIX2_CTRL: begin
					d.m2 = mic_mix_pkg::unpack_mix(reg_req_i.wdata);
				end
				mic_mix_pkg::ADDR_MIX1_GAIN: begin
					d.g1 = reg_req_i.wdata[mic_mix_pkg::GAIN_W-1:0];
				end
				mic_mix_pkg::ADDR_MIX2_GAIN: begin
					d.g2 = reg_req_i.wdata[mic_mix_pkg::GAIN_W-1:0];
				end
				default: begin
					d.src = q.src;
				end
			endcase
		end
		if (reg_req_i.rd) begin
			d.rdata = read_reg(q, reg_req_i.addr);
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			q <= REGS_RST;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------
	// Gain appliers
	// ------------------------------------------------------------------
	gain_applier u_gain_one (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.target_i(q.g1),
		.ramp_i(q.m1.ramp),
		.zc_i(q.m1.zero_cross_update),
		.step_i(q.step),
		.zero_cross_i(mixer_one_signal_zero_i),
		.gain_o(mixer_one_gain_o)
	);

	gain_applier u_gain_two (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.target_i(q.g2),
		.ramp_i(q.m2.ramp),
		.zc_i(q.m2.zero_cross_update),
		.step_i(q.step),
		.zero_cross_i(mixer_two_signal_zero_i),
		.gain_o(mixer_two_gain_o)
	);

	assign reg_rdata_o = q.rdata;
	assign preamp_two_src_o = q.src;
	assign bias_one_o = q.b1;
	assign bias_two_o = q.b2;
	assign mixer_one_o = q.m1;
	assign mixer_two_o = q.m2;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);

	a_src_after_write: assert property (
		(reg_req_i.wr && reg_req_i.addr == mic_mix_pkg::ADDR_SRC)
		|=> preamp_two_src_o == $past(reg_req_i.wdata[mic_mix_pkg::SRC_W-1:0]))
		else $error("preamp source not written");
	a_src_reset_zero: assert property (
		$past(sys_rst_i) |-> preamp_two_src_o == mic_mix_pkg::SRC_RST)
		else $error("preamp source reset wrong");
	a_bias_level_write: assert property (
		(reg_req_i.wr && reg_req_i.addr == mic_mix_pkg::ADDR_BIAS_SETUP)
		|=> bias_two_o.level == $past(reg_req_i.wdata[mic_mix_pkg::BIAS2_LVL_LSB +: mic_mix_pkg::LVL_W])
		&& bias_one_o.level == $past(reg_req_i.wdata[mic_mix_pkg::BIAS1_LVL_LSB +: mic_mix_pkg::LVL_W]))
		else $error("bias level not written");
	a_bias_lp_write: assert property (
		(reg_req_i.wr && reg_req_i.addr == mic_mix_pkg::ADDR_BIAS_SETUP)
		|=> bias_two_o.low_power == $past(reg_req_i.wdata[mic_mix_pkg::BIAS2_LP_BIT])
		&& bias_one_o.low_power == $past(reg_req_i.wdata[mic_mix_pkg::BIAS1_LP_BIT]))
		else $error("bias low power not written");
	a_bias_enable_write: assert property (
		(reg_req_i.wr && reg_req_i.addr == mic_mix_pkg::ADDR_BIAS_EN)
		|=> bias_two_o.enable == $past(reg_req_i.wdata[mic_mix_pkg::BIAS2_EN_BIT])
		&& bias_one_o.enable == $past(reg_req_i.wdata[mic_mix_pkg::BIAS1_EN_BIT]))
		else $error("bias enable not written");
	a_amp_en_write: assert property (
		(reg_req_i.wr && reg_req_i.addr == mic_mix_pkg::ADDR_MIX1_CTRL)
		|=> mixer_one_o.amp_en == $past(reg_req_i.wdata[mic_mix_pkg::MIX_AMP_EN_BIT]))
		else $error("amplifier enable not written");
	a_mute_at_reset: assert property (
		$past(sys_rst_i) |-> mixer_one_o.mute && mixer_two_o.mute && !mixer_one_o.amp_en)
		else $error("mixers not muted after reset");
	a_mix_en_reset: assert property (
		$past(sys_rst_i) |-> mixer_one_o.mix_en && mixer_two_o.mix_en)
		else $error("mixer enable reset wrong");
	a_gain_reset_value: assert property (
		$past(sys_rst_i) |-> mixer_one_gain_o == mic_mix_pkg::GAIN_RST
		&& mixer_two_gain_o == mic_mix_pkg::GAIN_RST)
		else $error("gain reset wrong");
	a_reserved_read_zero: assert property (
		(reg_req_i.rd && reg_req_i.addr == mic_mix_pkg::ADDR_BIAS_EN)
		|=> (reg_rdata_o & ~mic_mix_pkg::BIAS_EN_MASK) == 8'h00)
		else $error("reserved bits read nonzero");
	a_mix_one_ctrl_write: assert property (
		(reg_req_i.wr && reg_req_i.addr == mic_mix_pkg::ADDR_MIX1_CTRL)
		|=> mic_mix_pkg::pack_mix(mixer_one_o)
		== ($past(reg_req_i.wdata) & mic_mix_pkg::MIX_CTRL_MASK))
		else $error("mixer one control not written");
	a_mix_two_ctrl_write: assert property (
		(reg_req_i.wr && reg_req_i.addr == mic_mix_pkg::ADDR_MIX2_CTRL)
		|=> mic_mix_pkg::pack_mix(mixer_two_o)
		== ($past(reg_req_i.wdata) & mic_mix_pkg::MIX_CTRL_MASK))
		else $error("mixer two control not written");
	a_ctrl_read_reserved: assert property (
		(reg_req_i.rd && (reg_req_i.addr == mic_mix_pkg::ADDR_MIX1_CTRL
		|| reg_req_i.addr == mic_mix_pkg::ADDR_MIX2_CTRL))
		|=> (reg_rdata_o & ~mic_mix_pkg::MIX_CTRL_MASK) == 8'h00)
		else $error("reserved control bits read nonzero");
	a_gain_read_reserved: assert property (
		(reg_req_i.rd && (reg_req_i.addr == mic_mix_pkg::ADDR_MIX1_GAIN
		|| reg_req_i.addr == mic_mix_pkg::ADDR_MIX2_GAIN))
		|=> (reg_rdata_o & ~mic_mix_pkg::GAIN_MASK) == 8'h00)
		else $error("reserved gain bits read nonzero");
	a_src_read_reserved: assert property (
		(reg_req_i.rd && reg_req_i.addr == mic_mix_pkg::ADDR_SRC)
		|=> (reg_rdata_o & ~mic_mix_pkg::SRC_MASK) == 8'h00)
		else $error("reserved source bits read nonzero");

endmodule

// ---- mic_mix_regs_bench.sv ----
// Self-checking testbench for the record front-end register bank.
// Assumes the bank's strobe register port, mic_mix_pkg, and a 100 MHz mclk_i.
`timescale 1ns/10ps
module mic_mix_regs_bench;

	// ------------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------------
	logic mclk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	mic_mix_pkg::reg_req_t req = '0;
	logic [1:0] zero = 2'h0;
	logic [7:0] rdata;
	logic [1:0] src;
	mic_mix_pkg::bias_t b1;
	mic_mix_pkg::bias_t b2;
	mic_mix_pkg::mixer_ctrl_t m1;
	mic_mix_pkg::mixer_ctrl_t m2;
	logic [3:0] g1;
	logic [3:0] g2;
	int n_fail = 0;
	int checks = 0;
	logic [7:0] addr_tab [7] = '{8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'hbb, 8'hfc, 8'hfd};
	logic [7:0] rst_tab [7] = '{8'h48, 8'h03, 8'h48, 8'h03, 8'h00, 8'h00, 8'h00};
	logic [7:0] mask_tab [7] = '{8'hf8, 8'h0f, 8'hf8, 8'h0f, 8'h03, 8'hff, 8'h11};

	always #5 mclk_i = ~mclk_i;

	mic_mix_regs mic_mix_regs_inst (
		.mclk_i(mclk_i),
		.sys_rst_i(sys_rst_i),
		.reg_req_i(req),
		.mixer_one_signal_zero_i(zero[0]),
		.mixer_two_signal_zero_i(zero[1]),
		.reg_rdata_o(rdata),
		.preamp_two_src_o(src),
		.bias_one_o(b1),
		.bias_two_o(b2),
		.mixer_one_o(m1),
		.mixer_two_o(m2),
		.mixer_one_gain_o(g1),
		.mixer_two_gain_o(g2)
	);

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		#1;
		req.addr = a;
		req.wdata = d;
		req.wr = 1'b1;
		@(posedge mclk_i);
		#1;
		req.wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		#1;
		req.addr = a;
		req.rd = 1'b1;
		@(posedge mclk_i);
		#1;
		req.rd = 1'b0;
		d = rdata;
	endtask

	function automatic logic [3:0] gain_of(input int m);
		return m ? g2 : g1;
	endfunction

	task automatic complete_run();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Watchdog
	// ------------------------------------------------------------------
	initial begin
		#300000;
		n_fail++;
		complete_run();
	end

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial begin
		logic [7:0] v;
		logic [7:0] ca;
		int k;
		cyc(20);
		sys_rst_i = 1'b0;
		// Reset values on outputs and read-back
		check("mix1 fields", {3'h0, m1}, 8'h09);
		check("mix2 fields", {3'h0, m2}, 8'h09);
		check("gains", {g2, g1}, 8'h33);
		check("bias one reset", {3'h0, b1}, 8'h00);
		check("bias two reset", {3'h0, b2}, 8'h00);
		check("source reset", {6'h0, src}, 8'h00);
		for (int i = 0; i < 7; i++) begin
			rd(addr_tab[i], v);
			check("reset read", v, rst_tab[i]);
		end
		$display("test reset done");
		// All ones: reserved bits drop, unmapped place reads zero
		for (int i = 0; i < 7; i++) begin
			wr(addr_tab[i], 8'hff);
			rd(addr_tab[i], v);
			check("masked read", v, mask_tab[i]);
		end
		wr(8'h30, 8'hff);
		rd(8'h30, v);
		check("unmapped read", v, 8'h00);
		check("all ones bias two", {3'h0, b2}, 8'h1f);
		check("all ones bias one", {3'h0, b1}, 8'h1f);
		check("all ones mix two", {3'h0, m2}, 8'h1f);
		check("all ones mix one", {3'h0, m1}, 8'h1f);
		$display("test reserved done");
		// Bias and source field placement, regulators disabled before each change
		wr(8'hfd, 8'h00);
		wr(8'hfc, 8'ha5);
		check("bias two", {3'h0, b2}, 8'h14);
		check("bias one", {3'h0, b1}, 8'h0a);
		wr(8'hfd, 8'h10);
		check("enable two", {6'h0, b2.enable, b1.enable}, 8'h02);
		wr(8'hfd, 8'h01);
		check("enable one", {6'h0, b2.enable, b1.enable}, 8'h01);
		for (int i = 0; i < 8; i++) begin
			wr(8'hfd, 8'h00);
			wr(8'hfc, {1'b0, 3'(i), 1'b1, 3'(7 - i)});
			check("level two", {5'h0, b2.level}, 8'(i));
			check("level one", {5'h0, b1.level}, 8'(7 - i));
			check("lp bits", {6'h0, b2.low_power, b1.low_power}, 8'h01);
		end
		for (int i = 0; i < 3; i++) begin
			wr(8'hbb, 8'(i));
			check("source", {6'h0, src}, 8'(i));
		end
		$display("test fields done");
		// Gain application per mixer: instant, zero-cross, ramp over zero-cross
		for (int m = 0; m < 2; m++) begin
			ca = 8'h2c + 8'(2 * m);
			wr(ca, 8'h08);
			wr(ca + 8'h01, 8'h00);
			cyc(1);
			check("gain low", {4'h0, gain_of(m)}, 8'h00);
			wr(ca + 8'h01, 8'h0a);
			cyc(1);
			check("gain instant", {4'h0, gain_of(m)}, 8'h0a);
			wr(ca, 8'h18);
			wr(ca + 8'h01, 8'h05);
			cyc(5);
			check("gain held", {4'h0, gain_of(m)}, 8'h0a);
			zero[m] = 1'b1;
			cyc(1);
			zero[m] = 1'b0;
			cyc(1);
			check("gain at zero", {4'h0, gain_of(m)}, 8'h05);
			wr(ca, 8'h38);
			zero[m] = 1'b1;
			wr(ca + 8'h01, 8'h07);
			for (k = 0; k < 150 && gain_of(m) === 4'h5; k++)
				cyc(1);
			check("ramp first step", {4'h0, gain_of(m)}, 8'h06);
			for (k = 0; k < 150 && gain_of(m) === 4'h6; k++)
				cyc(1);
			check("ramp second step", {4'h0, gain_of(m)}, 8'h07);
			zero[m] = 1'b0;
			rd(ca + 8'h01, v);
			check("gain read", v, 8'h07);
		end
		$display("test gain done");
		// Reset in mid-run restores every field and the applied gains
		sys_rst_i = 1'b1;
		cyc(2);
		sys_rst_i = 1'b0;
		check("gains after reset", {g2, g1}, 8'h33);
		check("mix1 after reset", {3'h0, m1}, 8'h09);
		check("mix2 after reset", {3'h0, m2}, 8'h09);
		for (int i = 0; i < 7; i++) begin
			rd(addr_tab[i], v);
			check("reset again read", v, rst_tab[i]);
		end
		$display("test reset again done");
		complete_run();
	end

endmodule
